// File: rtl/dtz_cfg.svh
// Constants of the digital port and totalizer block: offsets, fields,
// reset values and timing. Expects to be included by the package and top.
`ifndef DTZ_CFG_SVH
`define DTZ_CFG_SVH

// Widths
`define DTZ_PORT_W      8
`define DTZ_CNT_W       26
`define DTZ_STAMP_W     16
`define DTZ_ADDR_W      8

// Byte offsets of the word registers
`define DTZ_OFS_PORT0   8'h00
`define DTZ_OFS_PORT1   8'h04
`define DTZ_OFS_WORD    8'h08
`define DTZ_OFS_DIR     8'h0c
`define DTZ_OFS_SCAN    8'h10
`define DTZ_OFS_CMD     8'h14
`define DTZ_OFS_COUNT   8'h18
`define DTZ_OFS_MON     8'h1c
`define DTZ_OFS_CFG     8'h20
`define DTZ_OFS_LIMIT   8'h24
`define DTZ_OFS_PAT     8'h28
`define DTZ_OFS_AMAP    8'h2c
`define DTZ_OFS_STATUS  8'h30
`define DTZ_OFS_SNAP    8'h34
`define DTZ_OFS_SCNT    8'h38

// Command register bits
`define DTZ_CMD_CARD    0
`define DTZ_CMD_LOCAL   1
`define DTZ_CMD_LSEL    2
`define DTZ_CMD_CLEAR   3
`define DTZ_CMD_SWEEP   4

// Status register bits
`define DTZ_ST_ERR      4

// Reset values
`define DTZ_RST_DIR     2'h0
`define DTZ_RST_SCAN    3'h0
`define DTZ_RST_CFG     8'h00

// Timing: fastest counted pulse rate and module clock rate
`define DTZ_MAX_RATE_HZ 100000
`define DTZ_CLK_HZ      25000000
`define DTZ_SYNC_CYC    4

`endif

// File: rtl/dtz_pkg.sv
// Types of the digital port and totalizer block.
// Assumes dtz_cfg.svh is on the include path.
`include "dtz_cfg.svh"

package dtz_pkg;

  // Pattern alarm flavour per port
  typedef enum logic {
    DTZ_PAT_EQ  = 1'b0,
    DTZ_PAT_CHG = 1'b1
  } dtz_pmode_t;

  // Software configuration word
  typedef struct packed {
    dtz_pmode_t [1:0] pmode;    // Bits 7:6
    logic [1:0]       pat_en;   // Bits 5:4
    logic             rsvd;     // Bit 3
    logic             lim_en;   // Bit 2
    logic             slope_rise; // Bit 1
    logic             rr_mode;  // Bit 0
  } dtz_cfg_t;

  // Whole state of the block
  typedef struct packed {
    logic                    waitreq;
    logic [31:0]             rdata;
    logic [15:0]             port_out;
    logic [1:0]              dir;
    logic [2:0]              scan;
    dtz_cfg_t                cfg;
    logic [`DTZ_CNT_W-1:0]   count;
    logic [`DTZ_CNT_W-1:0]   limit;
    logic [31:0]             pat;
    logic [5:0]              amap;
    logic                    err;
    logic [3:0]              alarm;
    logic [2:0]              sync1;
    logic [2:0]              sync2;
    logic [2:0]              sync3;
    logic [15:0]             prev_in;
    logic [`DTZ_STAMP_W-1:0] stamp;
    logic [31:0]             snap;
    logic [`DTZ_CNT_W-1:0]   scnt;
  } dtz_state_t;

endpackage : dtz_pkg

// File: rtl/dtz_top.sv
// Two 8-bit digital ports and a 26-bit gated event counter behind an
// Avalon-MM slave. Port pins are split into in/out/enable; counter and
// gate inputs are asynchronous and get synchronised here.
// Behaviour
// RULE1 - Two independent 8-bit ports; port 0 is low byte, port 1 high.
// RULE2 - Adding a port to the scan set forces only that port to input.
// RULE3 - Scanned port may be read but data and direction writes are refused.
// RULE4 - Word read only when neither port is scanned; else refused.
// RULE5 - Sweep samples both bytes together under one timestamp.
// RULE6 - Card reset command returns both ports to input.
// RULE7 - Local card reset returns only the selected port to input.
// RULE8 - Output direction refused for a scanned port.
// RULE9 - Byte write to one port or word write to both at once.
// RULE10 - 26-bit counter counts pulses up to 100 kHz.
// RULE11 - Counts rising or falling edge as slope setting selects.
// RULE12 - Counts only while high gate high and low gate low.
// RULE13 - Unwired gates float to enabled, so counting is continuous.
// RULE14 - After the maximum count the next edge wraps to zero.
// RULE15 - Read-and-clear read zeroes count atomically, losing no edge.
// RULE16 - Scanned counter in read-and-clear mode clears on each sweep.
// RULE17 - Monitor reads never clear the count.
// RULE18 - Card reset zeroes the count.
// RULE19 - Immediate clear zeroes the count at once, scanning or not.
// RULE20 - Enabled alarms are evaluated every cycle regardless of scanning.
// RULE21 - Per port alarm on a pattern or on a pattern change.
// RULE22 - Pattern test: (value xor ref) and mask; zero means equal.
// RULE23 - Each alarm output is the OR of its assigned sources.
// RULE24 - Counter and gates synchronised before edge detection.
`timescale 1ns/1ps
`include "dtz_cfg.svh"

module dtz_top
  import dtz_pkg::*;
#(
  parameter int CLK_HZ      = `DTZ_CLK_HZ,
  parameter int MAX_RATE_HZ = `DTZ_MAX_RATE_HZ
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Digital port pins, port 0 in bits 7:0
  input  wire logic [15:0] port_in_i,
  output logic      [15:0] port_out_o,
  output logic      [15:0] port_oe_o,
  // Counter input and gates
  input  wire logic        cnt_in_i,
  input  wire logic        gate_hi_i,
  input  wire logic        gate_lo_n_i,
  // Alarm lines
  output logic      [3:0]  alarm_o
);

  // Clock cycles in one period of a pulse at the top counted rate
  localparam int MIN_PERIOD_CYC = CLK_HZ / MAX_RATE_HZ;

  if (MIN_PERIOD_CYC < 2 * `DTZ_SYNC_CYC) begin : g_rate_check
    $error("dtz_top: clock too slow for the counter pulse rate");
  end

  dtz_state_t s;
  dtz_state_t n;

  logic [31:0] wmask;
  logic [31:0] wd;
  logic        take;
  logic        done;
  logic        rise;
  logic        fall;
  logic        gate_ok;
  logic        inc;
  logic        cnt_clr;
  logic [2:0]  added;
  logic [2:0]  src;
  logic [7:0]  pv [2];
  logic        word_ok;

  // Byte lanes of the write data
  always_comb begin
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  end

  // Next state of the whole block
  always_comb begin
    n       = s;
    wd      = avs_writedata_i & wmask;
    take    = (avs_read_i | avs_write_i) & s.waitreq;
    done    = (avs_read_i | avs_write_i) & ~s.waitreq;
    cnt_clr = 1'b0;
    added   = 3'h0;
    src     = 3'h0;
    pv[0]   = 8'h00;
    pv[1]   = 8'h00;
    word_ok = ~(|s.scan[1:0]);

    // Two-stage sync, third stage only for edge detect; see RULE24
    n.sync1 = {gate_lo_n_i, gate_hi_i, cnt_in_i};
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;

    // Free-running timestamp and previous port value
    n.stamp   = s.stamp + 16'h0001;
    n.prev_in = port_in_i;

    // Edge select and gating; see RULE11 see RULE12 see RULE13
    rise    = s.sync2[0] & ~s.sync3[0];
    fall    = ~s.sync2[0] & s.sync3[0];
    gate_ok = s.sync2[1] & ~s.sync2[2];
    inc     = gate_ok & (s.cfg.slope_rise ? rise : fall);

    // Count with natural wrap of the 26-bit field; see RULE10 see RULE14
    n.count = s.count + `DTZ_CNT_W'(inc);

    // Handshake: one wait cycle, then one cycle with waitrequest low
    n.waitreq = ~take;

    // Read data captured at the edge that drops waitrequest
    if (take && avs_read_i) begin
      unique case (avs_address_i)
        `DTZ_OFS_PORT0:  n.rdata = {24'h000000, port_in_i[7:0]};
        `DTZ_OFS_PORT1:  n.rdata = {24'h000000, port_in_i[15:8]};
        `DTZ_OFS_WORD: begin
          // Word read only with neither port scanned; see RULE4
          n.rdata = word_ok ? {16'h0000, port_in_i} : 32'h00000000;
        end
        `DTZ_OFS_DIR:    n.rdata = {30'h00000000, s.dir};
        `DTZ_OFS_SCAN:   n.rdata = {29'h00000000, s.scan};
        `DTZ_OFS_COUNT: begin
          n.rdata = {6'h00, s.count};
          // Clear in the same edge, keeping an edge that lands now
          cnt_clr = s.cfg.rr_mode; // see RULE15
        end
        // Monitor path leaves the count alone; see RULE17
        `DTZ_OFS_MON:    n.rdata = {6'h00, s.count};
        `DTZ_OFS_CFG:    n.rdata = {24'h000000, s.cfg};
        `DTZ_OFS_LIMIT:  n.rdata = {6'h00, s.limit};
        `DTZ_OFS_PAT:    n.rdata = s.pat;
        `DTZ_OFS_AMAP:   n.rdata = {26'h0000000, s.amap};
        `DTZ_OFS_STATUS: n.rdata = {27'h0000000, s.err, s.alarm};
        `DTZ_OFS_SNAP:   n.rdata = s.snap;
        `DTZ_OFS_SCNT:   n.rdata = {6'h00, s.scnt};
        default:         n.rdata = 32'h00000000;
      endcase
    end

    // Refused word read marks the error flag; see RULE4
    if (take && avs_read_i && avs_address_i == `DTZ_OFS_WORD && !word_ok) begin
      n.err = 1'b1;
    end

    // Writes act at the edge that sees waitrequest low
    if (done && avs_write_i) begin
      unique case (avs_address_i)
        `DTZ_OFS_PORT0: begin
          // Scanned port takes no data; see RULE3
          if (s.scan[0]) n.err = 1'b1;
          else if (avs_byteenable_i[0]) n.port_out[7:0] = wd[7:0];
        end
        `DTZ_OFS_PORT1: begin
          if (s.scan[1]) n.err = 1'b1; // see RULE3
          else if (avs_byteenable_i[0]) n.port_out[15:8] = wd[7:0];
        end
        `DTZ_OFS_WORD: begin
          // Both bytes land in one edge; see RULE9 see RULE1
          if (|s.scan[1:0]) n.err = 1'b1; // see RULE3
          else n.port_out = (s.port_out & ~wmask[15:0]) | wd[15:0];
        end
        `DTZ_OFS_DIR: begin
          if (avs_byteenable_i[0]) begin
            // Output refused on a scanned port; see RULE8 see RULE3
            n.dir = wd[1:0] & ~s.scan[1:0];
            if (|(wd[1:0] & s.scan[1:0])) n.err = 1'b1;
          end
        end
        `DTZ_OFS_SCAN: begin
          if (avs_byteenable_i[0]) begin
            n.scan = wd[2:0];
            // Only a newly added port is forced to input; see RULE2
            added  = wd[2:0] & ~s.scan;
            n.dir  = s.dir & ~added[1:0];
          end
        end
        `DTZ_OFS_CMD: begin
          if (avs_byteenable_i[0]) begin
            if (wd[`DTZ_CMD_CARD]) begin
              n.dir   = `DTZ_RST_DIR; // see RULE6
              cnt_clr = 1'b1;         // see RULE18
            end
            if (wd[`DTZ_CMD_LOCAL]) begin
              n.dir[wd[`DTZ_CMD_LSEL]] = 1'b0; // see RULE7
            end
            if (wd[`DTZ_CMD_CLEAR]) cnt_clr = 1'b1; // see RULE19
            if (wd[`DTZ_CMD_SWEEP]) begin
              // One instant, one stamp for both bytes; see RULE5
              n.snap = {s.stamp, port_in_i};
              n.scnt = s.count;
              if (s.scan[2] && s.cfg.rr_mode) cnt_clr = 1'b1; // see RULE16
            end
          end
        end
        `DTZ_OFS_CFG: begin
          if (avs_byteenable_i[0]) n.cfg = dtz_cfg_t'(wd[7:0]);
        end
        `DTZ_OFS_LIMIT: begin
          n.limit = `DTZ_CNT_W'((s.limit & ~wmask[25:0]) | wd[25:0]);
        end
        `DTZ_OFS_PAT: n.pat = (s.pat & ~wmask) | wd;
        `DTZ_OFS_AMAP: begin
          if (avs_byteenable_i[0]) n.amap = wd[5:0];
        end
        `DTZ_OFS_STATUS: begin
          // Write one to clear; this clear is applied after any refusal set in this edge, so the clear wins
          if (avs_byteenable_i[0] && wd[`DTZ_ST_ERR]) n.err = 1'b0;
        end
        default: ;
      endcase
    end

    // A clear keeps an edge counted in this very cycle
    if (cnt_clr) n.count = `DTZ_CNT_W'(inc);

    // Pattern alarms per port, every cycle; see RULE20 see RULE21
    for (int p = 0; p < 2; p++) begin
      if (s.cfg.pmode[p] == DTZ_PAT_EQ) begin
        pv[p] = (port_in_i[8*p +: 8] ^ s.pat[8*p +: 8])
                & s.pat[16 + 8*p +: 8]; // see RULE22
        src[p] = s.cfg.pat_en[p] & (pv[p] == 8'h00);
      end else begin
        pv[p] = (port_in_i[8*p +: 8] ^ s.prev_in[8*p +: 8])
                & s.pat[16 + 8*p +: 8];
        src[p] = s.cfg.pat_en[p] & (pv[p] != 8'h00);
      end
    end
    src[2] = s.cfg.lim_en & (s.count >= s.limit); // see RULE20

    // Alarm line k is the OR of sources mapped to k; see RULE23
    for (int k = 0; k < 4; k++) begin
      n.alarm[k] = 1'b0;
      for (int j = 0; j < 3; j++) begin
        if (src[j] && s.amap[2*j +: 2] == 2'(k)) n.alarm[k] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s         <= '0;
      s.waitreq <= 1'b1;
      s.dir     <= `DTZ_RST_DIR;
      s.scan    <= `DTZ_RST_SCAN;
      s.cfg     <= dtz_cfg_t'(`DTZ_RST_CFG);
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata_o    = s.rdata;
  assign avs_waitrequest_o = s.waitreq;
  assign port_out_o        = s.port_out;
  assign port_oe_o         = {{8{s.dir[1]}}, {8{s.dir[0]}}};
  assign alarm_o           = s.alarm;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence q_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  a_bus_ack_once: assert property (take |=> q_ack)
    else $error("waitrequest did not drop for exactly one cycle");

  a_scan_forces_in: assert property ( // see RULE2
    done && avs_write_i && avs_address_i == `DTZ_OFS_SCAN
    && avs_byteenable_i[0] && wd[1] && !s.scan[1]
    && (s.scan[0] || !wd[0])
    |=> !s.dir[1] && s.dir[0] == $past(s.dir[0]))
    else $error("newly scanned port not forced to input");

  a_scanned_no_wr: assert property ( // see RULE3
    done && avs_write_i && avs_address_i == `DTZ_OFS_PORT1 && s.scan[1]
    |=> s.port_out[15:8] == $past(s.port_out[15:8]) && s.err)
    else $error("write to scanned port was not refused");

  a_word_read_gate: assert property ( // see RULE4
    take && avs_read_i && avs_address_i == `DTZ_OFS_WORD && |s.scan[1:0]
    |=> avs_readdata_o == 32'h00000000 && s.err)
    else $error("word read allowed with a scanned port");

  a_no_output_scan: assert property (!(s.dir[0] && s.scan[0])
    || $past(s.dir[0] && s.scan[0])) // see RULE8
    else $error("scanned port became an output");

  a_card_reset_in: assert property ( // see RULE6
    done && avs_write_i && avs_address_i == `DTZ_OFS_CMD
    && avs_byteenable_i[0] && wd[`DTZ_CMD_CARD]
    |=> s.dir == 2'h0 && s.count <= `DTZ_CNT_W'(1))
    else $error("card reset left an output or a count");

  a_rr_read_clear: assert property ( // see RULE15
    take && avs_read_i && avs_address_i == `DTZ_OFS_COUNT && s.cfg.rr_mode
    |=> s.count == `DTZ_CNT_W'($past(inc))
        && avs_readdata_o[25:0] == $past(s.count))
    else $error("read-and-clear lost the count or an edge");

  a_mon_keeps: assert property ( // see RULE17
    take && avs_read_i && avs_address_i == `DTZ_OFS_MON
    |=> s.count == $past(s.count) + `DTZ_CNT_W'($past(inc)))
    else $error("monitor read disturbed the count");

  a_count_wrap: assert property ( // see RULE14
    inc && s.count == '1 && !cnt_clr |=> s.count == '0)
    else $error("count did not wrap to zero");

  a_gate_hold: assert property ( // see RULE12
    !gate_ok && !(avs_read_i || avs_write_i) |=> $stable(s.count))
    else $error("count moved with the gate closed");

  a_sweep_stamp: assert property ( // see RULE5
    done && avs_write_i && avs_address_i == `DTZ_OFS_CMD
    && avs_byteenable_i[0] && wd[`DTZ_CMD_SWEEP]
    |=> s.snap == {$past(s.stamp), $past(port_in_i)})
    else $error("sweep bytes not taken together");

  a_limit_alarm: assert property ( // see RULE23
    s.cfg.lim_en && s.count >= s.limit && s.amap[5:4] == 2'h3
    |=> alarm_o[3])
    else $error("limit alarm not seen on its line");

  // Local reset of port 1 leaves port 0 as it was
  a_local_reset_one: assert property ( // see RULE7
    done && avs_write_i && avs_address_i == `DTZ_OFS_CMD
    && avs_byteenable_i[0] && wd[`DTZ_CMD_LOCAL] && !wd[`DTZ_CMD_CARD]
    && wd[`DTZ_CMD_LSEL]
    |=> !s.dir[1] && s.dir[0] == $past(s.dir[0]))
    else $error("local reset touched the other port");

  a_dir_refused: assert property ( // see RULE8
    done && avs_write_i && avs_address_i == `DTZ_OFS_DIR
    && avs_byteenable_i[0] && |(wd[1:0] & s.scan[1:0])
    |=> (s.dir & $past(s.scan[1:0])) == 2'h0 && s.err)
    else $error("scanned port took output direction");

  a_word_write: assert property ( // see RULE9
    done && avs_write_i && avs_address_i == `DTZ_OFS_WORD
    && avs_byteenable_i[1:0] == 2'h3 && !(|s.scan[1:0])
    |=> port_out_o == $past(avs_writedata_i[15:0]))
    else $error("word write did not set both bytes together");

  a_clear_now: assert property ( // see RULE19
    done && avs_write_i && avs_address_i == `DTZ_OFS_CMD
    && avs_byteenable_i[0] && wd[`DTZ_CMD_CLEAR]
    |=> s.count <= `DTZ_CNT_W'(1))
    else $error("immediate clear left a count");

  // Sweep of a scanned counter in read-and-clear mode empties it
  a_rr_sweep_clear: assert property ( // see RULE16
    done && avs_write_i && avs_address_i == `DTZ_OFS_CMD
    && avs_byteenable_i[0] && wd[`DTZ_CMD_SWEEP]
    && s.scan[2] && s.cfg.rr_mode
    |=> s.count <= `DTZ_CNT_W'(1) && s.scnt == $past(s.count))
    else $error("sweep did not clear the scanned count");

  a_pattern_eq: assert property ( // see RULE22
    s.cfg.pat_en[0] && s.cfg.pmode[0] == DTZ_PAT_EQ && s.amap[1:0] == 2'h1
    && ((port_in_i[7:0] ^ s.pat[7:0]) & s.pat[23:16]) == 8'h00
    |=> alarm_o[1])
    else $error("equal pattern did not raise its alarm line");

endmodule : dtz_top

// File: test/dtz_far_model.sv
// Far-side model: outside TTL drivers of the ports, counter and gates.
// Assumes the bench clocks it with the block clock.
`timescale 1ns/1ps

module dtz_far_model (
  // Clock
  input  wire logic        clk_i,
  // Controls from the bench
  input  wire logic [15:0] ext_i,
  input  wire logic        run_i,
  input  wire logic        gate_cut_i,
  // Block pins
  input  wire logic [15:0] port_out_i,
  input  wire logic [15:0] port_oe_i,
  output logic      [15:0] pin_o,
  output logic             cnt_o,
  output logic             gate_hi_o,
  output logic             gate_lo_n_o
);
  logic [2:0] tick  = 3'h0;
  logic       cnt_q = 1'b0;

  assign cnt_o = cnt_q;

  // Pin level: block drives where enabled, outside driver elsewhere
  assign pin_o = (port_oe_i & port_out_i) | (~port_oe_i & ext_i);
  // Unwired gates float to their enabling level
  assign gate_hi_o   = ~gate_cut_i;
  assign gate_lo_n_o = 1'b0;

  // Square wave, 5 clocks high and 5 low, starts low
  always @(posedge clk_i) begin
    if (run_i) begin
      tick <= (tick == 3'h4) ? 3'h0 : tick + 3'h1;
      if (tick == 3'h4) cnt_q <= ~cnt_q;
    end
  end
endmodule : dtz_far_model

// File: test/dtz_top_test.sv
// Self-checking bench of the port and counter block.
// Assumes dtz_pkg and dtz_far_model are compiled before it.
`timescale 1ns/1ps
`include "dtz_cfg.svh"

module dtz_top_test
  import dtz_pkg::*;
;
  logic        clk_i;
  logic        rst_b_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] port_in_i;
  logic [15:0] port_out_o;
  logic [15:0] port_oe_o;
  logic        cnt_in_i;
  logic        gate_hi_i;
  logic        gate_lo_n_i;
  logic [3:0]  alarm_o;
  logic [15:0] ext;
  logic        run;
  logic        gate_cut;
  logic [31:0] q;
  int          err_total;
  int          n_compared;

  dtz_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(4'hf),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .port_in_i(port_in_i),
    .port_out_o(port_out_o), .port_oe_o(port_oe_o), .cnt_in_i(cnt_in_i),
    .gate_hi_i(gate_hi_i), .gate_lo_n_i(gate_lo_n_i), .alarm_o(alarm_o));

  dtz_far_model far (.clk_i(clk_i), .ext_i(ext), .run_i(run),
    .gate_cut_i(gate_cut), .port_out_i(port_out_o), .port_oe_i(port_oe_o),
    .pin_o(port_in_i), .cnt_o(cnt_in_i), .gate_hi_o(gate_hi_i),
    .gate_lo_n_o(gate_lo_n_i));

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // Verdict and end of run
  task wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Compare one value
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    avs_writedata_i <= d;
    // Hold until a rising edge sees waitrequest low, then let go
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      err_total++;
      wrap_up();
    end
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Read a register and compare it
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rdc

  // Let n full pulses out of the model, then wait out the latency
  task pulses(input int n);
    @(posedge clk_i);
    run <= 1'b1;
    repeat (n * 10) @(posedge clk_i);
    run <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : pulses

  task set_ext(input logic [15:0] v);
    @(posedge clk_i);
    ext <= v;
    repeat (4) @(posedge clk_i);
  endtask : set_ext

  task t_reset();
    rdc("dir", `DTZ_OFS_DIR, 32'h0);
    rdc("count", `DTZ_OFS_MON, 32'h0);
    rdc("unmapped", 8'hfc, 32'h0);
  endtask : t_reset

  task t_word();
    wr(`DTZ_OFS_DIR, 32'h3);
    wr(`DTZ_OFS_WORD, 32'd10327);
    @(negedge clk_i);
    chk("oe", 32'hffff, {16'h0, port_oe_o});
    chk("pins", 32'h2857, {16'h0, port_out_o});
    rdc("low", `DTZ_OFS_PORT0, 32'h57);
    rdc("high", `DTZ_OFS_PORT1, 32'h28);
  endtask : t_word

  task t_scan();
    set_ext(16'ha500);
    wr(`DTZ_OFS_SCAN, 32'h2);
    rdc("dir", `DTZ_OFS_DIR, 32'h1);
    wr(`DTZ_OFS_PORT1, 32'hff);
    rdc("err", `DTZ_OFS_STATUS, 32'h10);
    rdc("high", `DTZ_OFS_PORT1, 32'ha5);
    wr(`DTZ_OFS_STATUS, 32'h10);
    wr(`DTZ_OFS_DIR, 32'h3);
    rdc("dir", `DTZ_OFS_DIR, 32'h1);
    rdc("err", `DTZ_OFS_STATUS, 32'h10);
    wr(`DTZ_OFS_STATUS, 32'h10);
    rdc("word", `DTZ_OFS_WORD, 32'h0);
    rdc("err", `DTZ_OFS_STATUS, 32'h10);
    wr(`DTZ_OFS_STATUS, 32'h10);
    wr(`DTZ_OFS_SCAN, 32'h0);
  endtask : t_scan

  task t_count();
    wr(`DTZ_OFS_CFG, 32'h2);
    pulses(3);
    rdc("mon", `DTZ_OFS_MON, 32'h3);
    rdc("mon", `DTZ_OFS_MON, 32'h3);
    gate_cut <= 1'b1;
    pulses(2);
    gate_cut <= 1'b0;
    rdc("gated", `DTZ_OFS_MON, 32'h3);
    wr(`DTZ_OFS_CFG, 32'h0);
    pulses(2);
    rdc("falls", `DTZ_OFS_MON, 32'h5);
    wr(`DTZ_OFS_CFG, 32'h1);
    rdc("count", `DTZ_OFS_COUNT, 32'h5);
    rdc("mon", `DTZ_OFS_MON, 32'h0);
    pulses(4);
    wr(`DTZ_OFS_SCAN, 32'h4);
    wr(`DTZ_OFS_CMD, 32'h10);
    rdc("swept", `DTZ_OFS_SCNT, 32'h4);
    rdc("mon", `DTZ_OFS_MON, 32'h0);
    pulses(1);
    wr(`DTZ_OFS_CMD, 32'h8);
    rdc("cleared", `DTZ_OFS_MON, 32'h0);
    wr(`DTZ_OFS_SCAN, 32'h0);
  endtask : t_count

  task t_cmd_reset();
    pulses(2);
    wr(`DTZ_OFS_DIR, 32'h3);
    wr(`DTZ_OFS_CMD, 32'h6);
    rdc("dir", `DTZ_OFS_DIR, 32'h1);
    wr(`DTZ_OFS_CMD, 32'h1);
    rdc("dir", `DTZ_OFS_DIR, 32'h0);
    rdc("count", `DTZ_OFS_MON, 32'h0);
  endtask : t_cmd_reset

  task t_sweep();
    set_ext(16'h3c5a);
    wr(`DTZ_OFS_SCAN, 32'h3);
    wr(`DTZ_OFS_CMD, 32'h10);
    bus(1'b0, `DTZ_OFS_SNAP, 32'h0);
    chk("snap", 32'h3c5a, {16'h0, q[15:0]});
    wr(`DTZ_OFS_SCAN, 32'h0);
  endtask : t_sweep

  task t_alarm();
    wr(`DTZ_OFS_PAT, 32'h00f00080);
    wr(`DTZ_OFS_AMAP, 32'h1);
    wr(`DTZ_OFS_CFG, 32'h10);
    set_ext(16'h0092);
    chk("alarm", 32'h0, {28'h0, alarm_o});
    set_ext(16'h0085);
    chk("alarm", 32'h2, {28'h0, alarm_o});
    wr(`DTZ_OFS_CFG, 32'h50);
    @(posedge clk_i);
    ext <= 16'h0095;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("change", 32'h2, {28'h0, alarm_o});
    set_ext(16'h0096);
    chk("change", 32'h0, {28'h0, alarm_o});
    wr(`DTZ_OFS_LIMIT, 32'h2);
    wr(`DTZ_OFS_AMAP, 32'h31);
    wr(`DTZ_OFS_CFG, 32'h4);
    chk("limit", 32'h0, {28'h0, alarm_o});
    pulses(2);
    chk("limit", 32'h8, {28'h0, alarm_o});
  endtask : t_alarm

  // Main sequence
  initial begin
    clk_i           = 1'b0;
    rst_b_i         = 1'b0;
    avs_address_i   = 8'h00;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = 32'h0;
    ext             = 16'h0000;
    run             = 1'b0;
    gate_cut        = 1'b0;
    err_total       = 0;
    n_compared      = 0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_word();
    t_scan();
    t_count();
    t_cmd_reset();
    t_sweep();
    t_alarm();
    wrap_up();
  end
endmodule : dtz_top_test
